/* File: common/imc_pkg.sv */
package imc_pkg;
    // word and check widths
    localparam int DATA_W = 32;
    localparam int DCHK_W = 7;
    localparam int TAG_W = 20;
    localparam int IDX_W = 6;
    localparam int ADDR_W = 32;
    localparam int OFF_W = ADDR_W - TAG_W - IDX_W;
    localparam int TENT_W = TAG_W + 1;
    localparam int TCHK_W = 6;
    localparam int NWAYS = 4;
    localparam int WAY_W = 2;
    localparam int SPM_AW = 14;
    localparam int SPM_PAD = ADDR_W - SPM_AW - 2;
    // trap status bit positions and reset value
    localparam int TS_W = 4;
    localparam int TS_SPM = 0;
    localparam int TS_TAG = 1;
    localparam int TS_CDM_MISS = 2;
    localparam int TS_CDM_TRAP = 3;
    localparam logic [TS_W-1:0] TS_RST = 4'h0;

    // sweep first so that an all-zero state is the reset state
    typedef enum logic [1:0] {ST_SWEEP, ST_IDLE, ST_FILL} imc_state_t;

    typedef struct packed {
        logic en;
        logic [SPM_AW-1:0] addr;
        logic [DATA_W-1:0] data;
    } imc_bus_wr_t;

    typedef struct packed {
        logic en;
        logic [SPM_AW-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [DCHK_W-1:0] chk;
    } imc_spm_wr_t;

    typedef struct packed {
        logic valid;
        logic [SPM_AW-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [DCHK_W-1:0] chk;
    } imc_spm_rd_t;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
        logic err;
    } imc_fetch_t;

    typedef struct packed {
        logic req;
        logic [IDX_W-1:0] index;
        logic [TAG_W-1:0] tag;
    } imc_lookup_t;

    typedef struct packed {
        logic valid;
        logic [TAG_W-1:0] tag;
        logic [TCHK_W-1:0] chk;
    } imc_tag_ent_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [DCHK_W-1:0] chk;
    } imc_cword_t;

    typedef struct packed {
        logic req;
        logic [ADDR_W-1:0] addr;
    } imc_fill_t;

    typedef struct packed {
        logic en;
        logic [WAY_W-1:0] way;
        logic [IDX_W-1:0] index;
        imc_cword_t word;
    } imc_cdm_wr_t;

    typedef struct packed {
        logic spm;
        logic tag;
        logic cdm;
    } imc_corr_t;
endpackage

/* File: logic/imc_secded.sv */
`timescale 1ns/10ps
module imc_secded
    import imc_pkg::*;
#(
    parameter int W = 32,
    parameter int C = 7
) (
    input wire logic [W-1:0] data,
    input wire logic [C-1:0] chk,
    output logic [C-1:0] gen,
    output logic [W-1:0] fixed,
    output logic sbe,
    output logic dbe
);
    logic [C-2:0] ham;
    logic [C-2:0] syn;
    logic ovr;

    // hamming bits over data placed at non power-of-two positions
    always_comb
    begin
        int k;
        k = 0;
        ham = '0;
        for (int p = 3; p < W + C; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                for (int b = 0; b < C - 1; b++)
                    if (p[b])
                        ham[b] = ham[b] ^ data[k];
                k++;
            end
        end
    end

    // top bit is overall parity, so odd weight means one flipped bit
    assign gen = {^{data, ham}, ham};
    assign syn = ham ^ chk[C-2:0];
    assign ovr = ^{data, chk};
    assign sbe = ovr;
    assign dbe = !ovr && (syn != '0);

    // flip only on a single error, never guess on a double
    always_comb
    begin
        int k;
        k = 0;
        fixed = data;
        for (int p = 3; p < W + C; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                fixed[k] = data[k] ^ (ovr && (syn == p[C-2:0]));
                k++;
            end
        end
    end
endmodule

/* File: logic/imc_tag_ram.sv */
`timescale 1ns/10ps
module imc_tag_ram
    import imc_pkg::*;
#(
    parameter int DW = TENT_W + TCHK_W,
    parameter int AW = IDX_W
) (
    input wire logic core_clk,
    input wire logic ce,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    // contents are not reset; the sweep gives them defined values
    always_ff @(posedge core_clk)
    begin
        if (ce)
        begin
            if (we)
                mem[waddr] <= wdata;
            if (re)
                rdata <= mem[raddr];
        end
    end
endmodule

/* File: logic/imc_instr_check.sv */
`timescale 1ns/10ps
// What this block does
// - in-cycle scratch SECDED corrects single, pulses count
// - scratch double error flags data, causes trap
// - deferred scratch: correct next cycle, count it
// - deferred scratch double error raises integrity trap
// - scratch written from bus with check bits
// - way hits only if check and tag match
// - all ways miss starts a line fill
// - check stored tags during fill, replace bad way
// - corrected tag value discarded, way just replaced
// - tag error in fill pulses correction to core
// - controller writes tag with precomputed check bits
// - reset or invalidate sweeps indices, clearing valid
// - sweep writes error-free tag and check pattern
// - in-cycle data parity error forces miss, replace
// - deferred data parity error raises integrity trap
// - controller writes cache data with check bits
// - cache data needs no reset or invalidation
// - SEC cache data corrects and pulses count
// - scratch double, cache parity and tag errors update trap status and address
module imc_instr_check
    import imc_pkg::*;
#(
    parameter bit SPM_DEFER = 1'b0,
    parameter bit CDM_DEFER = 1'b0,
    parameter bit CDM_SEC = 1'b0
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire imc_bus_wr_t bus_wr,
    output imc_spm_wr_t spm_wr,
    input wire imc_spm_rd_t spm_rd,
    output imc_fetch_t spm_fetch,
    input wire imc_lookup_t lookup,
    output logic look_busy,
    input wire imc_cword_t [NWAYS-1:0] cdm_rd,
    output imc_fetch_t cache_fetch,
    output imc_fill_t fill,
    input wire logic fill_done,
    input wire logic [DATA_W-1:0] fill_data,
    output imc_cdm_wr_t cdm_wr,
    input wire logic inval_req,
    output imc_corr_t corr,
    output logic program_integrity_error_trap,
    input wire logic trap_status_clr,
    output logic [TS_W-1:0] program_integrity_trap_status,
    output logic [ADDR_W-1:0] program_integrity_trap_address
);
    typedef struct packed {
        imc_state_t st;
        logic [IDX_W-1:0] sw_idx;
        logic inval_pend;
        logic busy;
        imc_spm_rd_t spm_raw;
        imc_spm_wr_t spm_wr;
        imc_fetch_t spm_out;
        logic lk_v;
        logic [IDX_W-1:0] lk_idx;
        logic [TAG_W-1:0] lk_tag;
        imc_tag_ent_t [NWAYS-1:0] tent;
        logic force_v;
        logic [WAY_W-1:0] force_w;
        logic [WAY_W-1:0] rr;
        logic cd_v;
        imc_cword_t cd_word;
        logic [ADDR_W-1:0] cd_addr;
        imc_fetch_t cache_out;
        imc_fill_t fill;
        imc_cdm_wr_t cdm_wr;
        imc_corr_t corr;
        logic trap;
        logic [TS_W-1:0] ts;
        logic [ADDR_W-1:0] ta;
    } imc_ck_state_t;

    imc_ck_state_t s;
    imc_ck_state_t next_s;

    imc_spm_rd_t spm_src;
    logic [DATA_W-1:0] spm_fix;
    logic spm_sbe;
    logic spm_dbe;
    logic [DCHK_W-1:0] spm_gen;
    imc_cword_t cd_src;
    logic [DATA_W-1:0] cd_sec_fix;
    logic [DATA_W-1:0] cd_fix;
    logic cd_sbe;
    logic cd_perr;
    logic [DCHK_W-1:0] fenc_gen;
    logic [DCHK_W-1:0] fill_chk;
    logic [TENT_W-1:0] tenc_in;
    logic [TCHK_W-1:0] tenc_gen;
    imc_tag_ent_t [NWAYS-1:0] rd_ent;
    logic [NWAYS-1:0] hit;
    logic [NWAYS-1:0] terr;
    logic [WAY_W-1:0] hit_w;
    logic [WAY_W-1:0] err_w;
    logic [WAY_W-1:0] victim;
    logic look_take;
    logic [NWAYS-1:0] tw_en;
    logic [IDX_W-1:0] tw_idx;
    imc_tag_ent_t tw_data;
    logic [TS_W-1:0] err_set;
    logic [ADDR_W-1:0] err_addr;
    logic [ADDR_W-1:0] line_addr;

    assign spm_src = SPM_DEFER ? s.spm_raw : spm_rd;
    assign cd_src = CDM_DEFER ? s.cd_word : cdm_rd[hit_w];

    // scratch read checker and bus-side encoder
    imc_secded #(.W(DATA_W), .C(DCHK_W)) u_spm_chk (.data(spm_src.data),
        .chk(spm_src.chk), .gen(), .fixed(spm_fix), .sbe(spm_sbe), .dbe(spm_dbe));
    imc_secded #(.W(DATA_W), .C(DCHK_W)) u_spm_enc (.data(bus_wr.data),
        .chk('0), .gen(spm_gen), .fixed(), .sbe(), .dbe());

    // cache data checker and fill encoder
    imc_secded #(.W(DATA_W), .C(DCHK_W)) u_cd_chk (.data(cd_src.data),
        .chk(cd_src.chk), .gen(), .fixed(cd_sec_fix), .sbe(cd_sbe), .dbe());
    imc_secded #(.W(DATA_W), .C(DCHK_W)) u_cd_enc (.data(fill_data),
        .chk('0), .gen(fenc_gen), .fixed(), .sbe(), .dbe());
    assign cd_perr = ^{cd_src.data, cd_src.chk[0]};
    assign cd_fix = CDM_SEC ? cd_sec_fix : cd_src.data;
    assign fill_chk = CDM_SEC ? fenc_gen : DCHK_W'(^fill_data);

    // expected tag check, also the all-zero pattern while sweeping
    assign tenc_in = (s.st == ST_SWEEP) ? '0 : {1'b1, s.lk_tag};
    imc_secded #(.W(TENT_W), .C(TCHK_W)) u_tag_enc (.data(tenc_in),
        .chk('0), .gen(tenc_gen), .fixed(), .sbe(), .dbe());

    assign look_take = lookup.req && !s.busy;
    assign line_addr = {s.lk_tag, s.lk_idx, {OFF_W{1'b0}}};

    // per-way tag store, comparator and fill-time checker
    for (genvar w = 0; w < NWAYS; w++)
    begin : g_way
        imc_tag_ram u_ram (.core_clk(core_clk), .ce(ce), .we(tw_en[w]),
            .waddr(tw_idx), .wdata(tw_data), .re(look_take),
            .raddr(lookup.index), .rdata(rd_ent[w]));
        assign hit[w] = s.lk_v && rd_ent[w].valid && (rd_ent[w].chk == tenc_gen)
            && (rd_ent[w].tag == s.lk_tag);
        imc_secded #(.W(TENT_W), .C(TCHK_W)) u_chk (
            .data({s.tent[w].valid, s.tent[w].tag}), .chk(s.tent[w].chk),
            .gen(), .fixed(), .sbe(terr[w]), .dbe());
    end

    // lowest hitting way and lowest bad way
    always_comb
    begin
        hit_w = '0;
        err_w = '0;
        for (int w = NWAYS - 1; w >= 0; w--)
        begin
            if (hit[w])
                hit_w = WAY_W'(w);
        end
        for (int w = NWAYS - 1; w >= 0; w--)
            if (terr[w])
                err_w = WAY_W'(w);
    end

    // forced way, then bad tag way, else round robin
    always_comb
    begin
        if (s.force_v)
            victim = s.force_w;
        else if (|terr)
            victim = err_w;
        else
            victim = s.rr;
    end

    // next state
    always_comb
    begin
        next_s = s;
        next_s.spm_out.valid = 1'b0;
        next_s.spm_out.err = 1'b0;
        next_s.cache_out.valid = 1'b0;
        next_s.cache_out.err = 1'b0;
        next_s.cdm_wr.en = 1'b0;
        next_s.corr = '0;
        next_s.lk_v = 1'b0;
        next_s.cd_v = 1'b0;
        tw_en = '0;
        tw_idx = s.lk_idx;
        tw_data = '{valid: 1'b1, tag: s.lk_tag, chk: tenc_gen};
        err_set = '0;
        err_addr = s.ta;
        next_s.inval_pend = s.inval_pend | inval_req;

        // bus write with encoded check bits
        next_s.spm_wr = '{en: bus_wr.en, addr: bus_wr.addr, data: bus_wr.data,
            chk: spm_gen};

        // scratch read; raw copy feeds the deferred form
        next_s.spm_raw = spm_rd;
        if (spm_src.valid)
        begin
            next_s.spm_out.valid = 1'b1;
            next_s.spm_out.data = spm_fix;
            next_s.corr.spm = spm_sbe;
            // double error rides with the data
            next_s.spm_out.err = spm_dbe;
            if (spm_dbe)
            begin
                err_set[TS_SPM] = 1'b1;
                err_addr = {{SPM_PAD{1'b0}}, spm_src.addr, 2'b00};
            end
        end

        // deferred cache data check, one cycle after the hit
        if (s.cd_v)
        begin
            // parity error becomes a trap; SEC corrects
            next_s.cache_out.valid = 1'b1;
            next_s.cache_out.data = cd_fix;
            next_s.cache_out.err = !CDM_SEC && cd_perr;
            next_s.corr.cdm = CDM_SEC && cd_sbe;
            if (!CDM_SEC && cd_perr)
            begin
                err_set[TS_CDM_TRAP] = 1'b1;
                err_addr = s.cd_addr;
            end
        end

        unique case (s.st)
            ST_SWEEP:
            begin
                // clear valid, write consistent check bits
                tw_en = '1;
                tw_idx = s.sw_idx;
                tw_data = '{valid: 1'b0, tag: '0, chk: tenc_gen};
                next_s.sw_idx = s.sw_idx + 1'b1;
                if (&s.sw_idx)
                begin
                    next_s.st = ST_IDLE;
                    next_s.inval_pend = inval_req;
                end
            end
            ST_IDLE:
            begin
                if (s.lk_v)
                begin
                    next_s.tent = rd_ent;
                    next_s.force_w = hit_w;
                    if (hit == '0)
                    begin
                        next_s.st = ST_FILL;
                        next_s.force_v = 1'b0;
                        next_s.fill = '{req: 1'b1, addr: line_addr};
                    end
                    else if (!CDM_DEFER && !CDM_SEC && cd_perr)
                    begin
                        next_s.st = ST_FILL;
                        next_s.force_v = 1'b1;
                        next_s.fill = '{req: 1'b1, addr: line_addr};
                        err_set[TS_CDM_MISS] = 1'b1;
                        err_addr = line_addr;
                    end
                    else if (CDM_DEFER)
                    begin
                        // raw check bits travel one more cycle
                        next_s.cd_v = 1'b1;
                        next_s.cd_word = cdm_rd[hit_w];
                        next_s.cd_addr = line_addr;
                    end
                    else
                    begin
                        next_s.cache_out.valid = 1'b1;
                        next_s.cache_out.data = cd_fix;
                        next_s.corr.cdm = CDM_SEC && cd_sbe;
                    end
                end
                else if (s.inval_pend)
                begin
                    next_s.st = ST_SWEEP;
                    next_s.sw_idx = '0;
                end
                else
                begin
                    next_s.lk_v = look_take;
                    if (look_take)
                    begin
                        next_s.lk_idx = lookup.index;
                        next_s.lk_tag = lookup.tag;
                    end
                end
            end
            ST_FILL:
            begin
                if (fill_done)
                begin
                    // new tag with its precomputed check bits
                    tw_en[victim] = 1'b1;
                    // data and check bits written together
                    next_s.cdm_wr = '{en: 1'b1, way: victim, index: s.lk_idx,
                        word: '{data: fill_data, chk: fill_chk}};
                    next_s.corr.tag = |terr;
                    if (|terr)
                    begin
                        err_set[TS_TAG] = 1'b1;
                        err_addr = line_addr;
                    end
                    next_s.fill.req = 1'b0;
                    next_s.force_v = 1'b0;
                    next_s.rr = s.rr + 1'b1;
                    next_s.st = ST_IDLE;
                end
            end
        endcase

        // set beats clear on the same edge
        next_s.ts = (s.ts & ~{TS_W{trap_status_clr}}) | err_set;
        next_s.ta = (err_set != '0) ? err_addr : s.ta;
        next_s.trap = next_s.spm_out.err | next_s.cache_out.err;
        next_s.busy = (next_s.st != ST_IDLE) | next_s.lk_v | next_s.inval_pend;
    end

    // data store has no clear path; only tags are swept
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s <= '0;
            s.busy <= 1'b1;
            s.ts <= TS_RST;
        end
        else if (ce)
            s <= next_s;
    end

    // every output is a state bit
    assign spm_wr = s.spm_wr;
    assign spm_fetch = s.spm_out;
    assign look_busy = s.busy;
    assign cache_fetch = s.cache_out;
    assign fill = s.fill;
    assign cdm_wr = s.cdm_wr;
    assign corr = s.corr;
    assign program_integrity_error_trap = s.trap;
    assign program_integrity_trap_status = s.ts;
    assign program_integrity_trap_address = s.ta;
endmodule

/* File: bench/imc_instr_check_checker.sv */
`timescale 1ns/10ps
module imc_instr_check_checker
    import imc_pkg::*;
#(
    parameter bit SPM_DEFER = 1'b0
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire imc_bus_wr_t bus_wr,
    input wire imc_spm_wr_t spm_wr,
    input wire imc_spm_rd_t spm_rd,
    input wire imc_fetch_t spm_fetch,
    input wire imc_lookup_t lookup,
    input wire logic look_busy,
    input wire imc_fill_t fill,
    input wire logic fill_done,
    input wire logic [DATA_W-1:0] fill_data,
    input wire imc_cdm_wr_t cdm_wr,
    input wire imc_corr_t corr,
    input wire logic program_integrity_error_trap,
    input wire logic trap_status_clr,
    input wire logic [TS_W-1:0] program_integrity_trap_status
);
    // edges since reset release; saturates so it never wraps into the sweep window
    logic [6:0] up_cnt;
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            up_cnt <= 7'h00;
        else if (ce && up_cnt != 7'h7F)
            up_cnt <= up_cnt + 7'h01;
    end

    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    scr_write_a: assert property (ce && bus_wr.en |=> spm_wr.en
        && spm_wr.data == $past(bus_wr.data) && spm_wr.addr == $past(bus_wr.addr))
        else $error("scratch write not forwarded");
    scr_fetch_a: assert property (ce && spm_rd.valid && !SPM_DEFER |=> spm_fetch.valid)
        else $error("scratch fetch late");
    defer_fetch_a: assert property (ce && spm_rd.valid && SPM_DEFER |=> ##1 spm_fetch.valid)
        else $error("deferred fetch late");
    double_trap_a: assert property (spm_fetch.valid && spm_fetch.err |->
        program_integrity_error_trap && program_integrity_trap_status[TS_SPM])
        else $error("double error without trap");
    corr_single_a: assert property (corr.spm |-> spm_fetch.valid && !spm_fetch.err)
        else $error("stray scratch correction");
    status_sticky_a: assert property (ce && !trap_status_clr |=>
        (program_integrity_trap_status & $past(program_integrity_trap_status))
        == $past(program_integrity_trap_status))
        else $error("trap status lost a bit");
    sweep_busy_a: assert property (up_cnt < 7'h40 |-> look_busy)
        else $error("busy dropped during sweep");
    look_taken_a: assert property (ce && lookup.req && !look_busy |=> look_busy)
        else $error("lookup taken without busy");
    fill_hold_a: assert property (fill.req && !fill_done |=> fill.req && $stable(fill.addr))
        else $error("fill request dropped early");
    fill_write_a: assert property (ce && fill.req && fill_done |=> !fill.req && cdm_wr.en
        && cdm_wr.word.data == $past(fill_data)
        && cdm_wr.index == $past(fill.addr[OFF_W +: IDX_W]))
        else $error("fill word not written");
endmodule

bind imc_instr_check imc_instr_check_checker #(.SPM_DEFER(SPM_DEFER)) u_imc_instr_check_checker (
    .core_clk, .rstn, .ce, .bus_wr, .spm_wr, .spm_rd, .spm_fetch, .lookup, .look_busy,
    .fill, .fill_done, .fill_data, .cdm_wr, .corr, .program_integrity_error_trap,
    .trap_status_clr, .program_integrity_trap_status);

/* File: bench/imc_far_model.sv */
`timescale 1ns/10ps
module imc_far_model
    import imc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire imc_spm_wr_t spm_wr,
    input wire logic rd_go,
    input wire logic [SPM_AW-1:0] rd_addr,
    input wire logic [DATA_W+DCHK_W-1:0] sflip,
    output imc_spm_rd_t spm_rd,
    input wire imc_lookup_t lookup,
    input wire logic look_busy,
    input wire logic [WAY_W-1:0] cflip_way,
    input wire logic [DATA_W+DCHK_W-1:0] cflip,
    output imc_cword_t [NWAYS-1:0] cdm_rd,
    input wire imc_cdm_wr_t cdm_wr,
    input wire imc_fill_t fill,
    input wire logic [3:0] fill_lat,
    output logic fill_done,
    output logic [DATA_W-1:0] fill_data
);
    imc_cword_t smem [16];
    imc_cword_t cmem [NWAYS][64];
    logic [3:0] wait_cnt;
    logic sent;
    // cache data never cleared, only garbage until filled
    initial
    begin
        foreach (cmem[w, i])
            cmem[w][i] = '1;
        cdm_rd = '0;
    end
    // memories; idle read lines toggle so stale data is never trusted
    always @(posedge core_clk)
    begin
        // word stored with its check bits
        if (spm_wr.en)
            smem[spm_wr.addr[3:0]] <= {spm_wr.data, spm_wr.chk};
        if (cdm_wr.en)
            cmem[cdm_wr.way][cdm_wr.index] <= cdm_wr.word;
        spm_rd.valid <= rd_go;
        spm_rd.addr <= rd_addr;
        if (rd_go)
            {spm_rd.data, spm_rd.chk} <= smem[rd_addr[3:0]] ^ sflip;
        else
            {spm_rd.data, spm_rd.chk} <= ~{spm_rd.data, spm_rd.chk};
        for (int w = 0; w < NWAYS; w++)
            if (lookup.req && !look_busy)
                cdm_rd[w] <= cmem[w][lookup.index] ^ ((cflip_way == WAY_W'(w)) ? cflip : '0);
            else
                cdm_rd[w] <= ~cdm_rd[w];
    end
    // line fetch answered after fill_lat cycles, once per request
    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fill_done <= 1'b0;
            fill_data <= '0;
            wait_cnt <= 4'h0;
            sent <= 1'b0;
        end
        else
        begin
            fill_done <= 1'b0;
            fill_data <= ~fill_data;
            if (!fill.req)
            begin
                wait_cnt <= 4'h0;
                sent <= 1'b0;
            end
            else if (!sent && wait_cnt == fill_lat)
            begin
                fill_done <= 1'b1;
                fill_data <= fill.addr ^ 32'h5A5A0F0F;
                sent <= 1'b1;
            end
            else if (!sent)
                wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

/* File: bench/tb_imc_instr_check.sv */
`timescale 1ns/10ps
module tb_imc_instr_check
    import imc_pkg::*;
;
    logic core_clk = 1'b0;
    logic rstn, ce, look_busy, fill_done, inval_req, trap_status_clr;
    logic program_integrity_error_trap, rd_go;
    imc_bus_wr_t bus_wr;
    imc_spm_wr_t spm_wr;
    imc_spm_rd_t spm_rd;
    imc_fetch_t spm_fetch, cache_fetch, sf, cf;
    imc_lookup_t lookup;
    imc_cword_t [NWAYS-1:0] cdm_rd;
    imc_fill_t fill;
    imc_cdm_wr_t cdm_wr, cw;
    imc_corr_t corr;
    logic [DATA_W-1:0] fill_data;
    logic [TS_W-1:0] program_integrity_trap_status;
    logic [ADDR_W-1:0] program_integrity_trap_address, fa;
    logic [SPM_AW-1:0] rd_addr;
    logic [DATA_W+DCHK_W-1:0] sflip, cflip;
    logic [WAY_W-1:0] cflip_way;
    logic [3:0] fill_lat;
    logic s_corr, s_trap, fr_d;
    int ev [4];
    int snap [4];
    int n_mismatch, total_checks, waited;

    always #10 core_clk = ~core_clk;

    imc_instr_check u_imc_instr_check (.core_clk, .rstn, .ce, .bus_wr, .spm_wr, .spm_rd,
        .spm_fetch, .lookup, .look_busy, .cdm_rd, .cache_fetch, .fill, .fill_done, .fill_data,
        .cdm_wr, .inval_req, .corr, .program_integrity_error_trap, .trap_status_clr,
        .program_integrity_trap_status, .program_integrity_trap_address);
    imc_far_model u_imc_far_model (.core_clk, .rstn, .spm_wr, .rd_go, .rd_addr, .sflip,
        .spm_rd, .lookup, .look_busy, .cflip_way, .cflip, .cdm_rd, .cdm_wr, .fill, .fill_lat,
        .fill_done, .fill_data);

    // one-cycle outputs latched so tasks can judge them later
    always @(posedge core_clk)
    begin
        fr_d <= fill.req;
        if (spm_fetch.valid)
        begin
            sf <= spm_fetch;
            s_corr <= corr.spm;
            s_trap <= program_integrity_error_trap;
            ev[0] <= ev[0] + 1;
        end
        if (cache_fetch.valid)
        begin
            cf <= cache_fetch;
            ev[1] <= ev[1] + 1;
        end
        if (cdm_wr.en)
        begin
            cw <= cdm_wr;
            ev[2] <= ev[2] + 1;
        end
        if (fill.req && !fr_d)
        begin
            fa <= fill.addr;
            ev[3] <= ev[3] + 1;
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // bounded wait for event k, or k == 4 for lookup path free
    task automatic await(input int k);
        bit done;
        done = 1'b0;
        waited = 0;
        while (!done && waited < 300)
        begin
            @(negedge core_clk);
            waited++;
            done = (k == 4) ? (look_busy === 1'b0) : (ev[k] != snap[k]);
        end
        if (!done)
        begin
            n_mismatch++;
            $display("MISMATCH wait %0d expected event seen none", k);
            finish_test();
        end
    endtask

    task automatic t_scratch(input logic [SPM_AW-1:0] a, input logic [DATA_W-1:0] d,
        input logic [DATA_W+DCHK_W-1:0] fl, input logic e_err, input logic e_corr);
        @(posedge core_clk);
        bus_wr <= '{1'b1, a, d};
        @(posedge core_clk);
        bus_wr.en <= 1'b0;
        repeat (2) @(posedge core_clk);
        snap = ev;
        rd_go <= 1'b1;
        rd_addr <= a;
        sflip <= fl;
        @(posedge core_clk);
        rd_go <= 1'b0;
        await(0);
        if (!e_err)
            check("fetch data", 64'(sf.data), 64'(d));
        check("fetch err", 64'(sf.err), 64'(e_err));
        check("trap", 64'(s_trap), 64'(e_err));
        check("corr", 64'(s_corr), 64'(e_corr));
        if (e_err)
            check("addr", 64'(program_integrity_trap_address), 64'({a, 2'b00}));
    endtask

    task automatic t_look(input logic [TAG_W-1:0] tg, input logic [IDX_W-1:0] ix,
        input logic hit, input logic [WAY_W-1:0] way);
        await(4);
        snap = ev;
        @(posedge core_clk);
        lookup <= '{1'b1, ix, tg};
        @(posedge core_clk);
        lookup.req <= 1'b0;
        if (hit)
        begin
            await(1);
            check("hit data", 64'(cf.data), 64'({tg, ix, 6'h00} ^ 32'h5A5A0F0F));
            check("hit err", 64'(cf.err), 64'h0);
        end
        else
        begin
            await(3);
            check("fill addr", 64'(fa), 64'({tg, ix, 6'h00}));
            await(2);
            check("victim", 64'(cw.way), 64'(way));
            check("fill index", 64'(cw.index), 64'(ix));
        end
    endtask

    initial
    begin
        rstn = 1'b0;
        ce = 1'b1;
        bus_wr = '0;
        lookup = '0;
        inval_req = 1'b0;
        trap_status_clr = 1'b0;
        rd_go = 1'b0;
        rd_addr = '0;
        sflip = '0;
        cflip = '0;
        cflip_way = '0;
        fill_lat = 4'h0;
        repeat (3) @(posedge core_clk);
        check("busy in reset", 64'(look_busy), 64'h1);
        rstn <= 1'b1;
        await(4);
        check("sweep length", 64'(waited > 63 && waited < 70), 64'h1);
        t_scratch(14'h0005, 32'h12345678, '0, 1'b0, 1'b0);
        t_scratch(14'h0006, 32'hCAFE0001, 39'h1 << 12, 1'b0, 1'b1);
        t_scratch(14'h0007, 32'h0F0F00FF, 39'h2, 1'b0, 1'b1);
        t_scratch(14'h3FFF, 32'hFFFF0000, 39'h3000, 1'b1, 1'b0);
        check("spm status", 64'(program_integrity_trap_status), 64'h1);
        @(posedge core_clk);
        trap_status_clr <= 1'b1;
        @(posedge core_clk);
        trap_status_clr <= 1'b0;
        @(negedge core_clk);
        check("status clr", 64'(program_integrity_trap_status), 64'h0);
        t_look(20'hABCDE, 6'h3F, 1'b0, 2'h0);
        t_look(20'hABCDE, 6'h3F, 1'b1, 2'h0);
        cflip <= 39'h1;
        fill_lat <= 4'h9;
        t_look(20'hABCDE, 6'h3F, 1'b0, 2'h0);
        check("parity status", 64'(program_integrity_trap_status[TS_CDM_MISS]), 64'h1);
        check("parity addr", 64'(program_integrity_trap_address), 64'({20'hABCDE, 12'hFC0}));
        cflip <= '0;
        t_look(20'hABCDE, 6'h3F, 1'b1, 2'h0);
        await(4);
        @(posedge core_clk);
        inval_req <= 1'b1;
        @(posedge core_clk);
        inval_req <= 1'b0;
        repeat (3) @(negedge core_clk);
        check("inval busy", 64'(look_busy), 64'h1);
        t_look(20'hABCDE, 6'h3F, 1'b0, 2'h2);
        finish_test();
    end
endmodule
